/* hdl/smc_pkg.sv */
// Constants shared by the synthesizer main control block.
// Assumes a 32-bit APB register port, one aligned word per register.
package smc_pkg;

	// ------------------------------------------------------------
	// Register indices and byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] SMC_MAIN_IDX    = 8'h00;             // Main control register index
	localparam logic [7:0] SMC_CALDIV_IDX  = 8'h01;             // Calibration clock divider index
	localparam logic [7:0] SMC_STATUS_IDX  = 8'h02;             // Block status index
	localparam logic [9:0] SMC_MAIN_ADDR   = {SMC_MAIN_IDX, 2'b00};
	localparam logic [9:0] SMC_CALDIV_ADDR = {SMC_CALDIV_IDX, 2'b00};
	localparam logic [9:0] SMC_STATUS_ADDR = {SMC_STATUS_IDX, 2'b00};

	// ------------------------------------------------------------
	// Main control field positions
	// ------------------------------------------------------------
	localparam int SMC_PHASE_BIT  = 14;                         // Deterministic phase enable
	localparam int SMC_MUTE_BIT   = 9;                          // Mute during calibration
	localparam int SMC_ADJ_HI     = 8;                          // Calibration speed adjust, high
	localparam int SMC_ADJ_LO     = 7;                          // Calibration speed adjust, low
	localparam int SMC_VCO_FREQUENCY_CALIBRATION_BIT   = 3;                          // Calibration trigger
	localparam int SMC_MUXSEL_BIT = 2;                          // Output pin function select
	localparam int SMC_RESET_BIT  = 1;                          // Software reset
	localparam int SMC_SLEEP_BIT  = 0;                          // Device sleep

	// ------------------------------------------------------------
	// Values after reset
	// ------------------------------------------------------------
	localparam logic       SMC_PHASE_RST  = 1'b0;
	localparam logic       SMC_MUTE_RST   = 1'b0;
	localparam logic [1:0] SMC_ADJ_RST    = 2'h0;
	localparam logic       SMC_VCO_FREQUENCY_CALIBRATION_RST   = 1'b1;
	localparam logic       SMC_MUXSEL_RST = 1'b1;
	localparam logic       SMC_RESET_RST  = 1'b0;
	localparam logic       SMC_SLEEP_RST  = 1'b0;
	localparam logic [2:0] SMC_CALDIV_RST = 3'h4;

	// ------------------------------------------------------------
	// Counts
	// ------------------------------------------------------------
	localparam int SMC_CAL_TICKS = 32;                          // State machine ticks per calibration

	// Calibration sequencer states
	typedef enum logic [0:0] {
		SMC_CAL_IDLE = 1'b0,
		SMC_CAL_RUN  = 1'b1
	} smc_cal_state_type;

endpackage

/* hdl/smc_cal_if.sv */
// Signals between the control register and the calibration engine.
// Assumes every party runs on the one system clock.
`timescale 1ns/1ps
interface smc_cal_if;
	logic       tick;   // State machine clock enable
	logic [3:0] exp;    // Divide exponent, power of two
	logic       start;  // Launch a calibration, one cycle
	logic       clear;  // Hold engine in reset
	logic       busy;   // Calibration in progress
	logic       done;   // Calibration finished, one cycle

	modport ctrl (output exp, start, clear, input tick, busy, done);
	modport div  (input exp, clear, output tick);
	modport seq  (input tick, start, clear, output busy, done);
endinterface

/* hdl/smc_cal_divider.sv */
// Divider that makes the state machine clock enable from the reference.
// Assumes the system clock stands for the reference input.
`timescale 1ns/1ps
module smc_cal_divider
	import smc_pkg::*;
#(
	parameter int CNT_W = 11                         // Covers exponents up to ten
) (
	input  wire logic clk_i,
	input  wire logic resetn_i,
	smc_cal_if.div    cif
);

	logic [CNT_W-1:0] cnt_r;                         // Reference cycles counted
	logic [CNT_W-1:0] limit_w;                       // Last count before a tick
	logic             wrap_w;                        // Period complete

	assign limit_w = (({{(CNT_W-1){1'b0}}, 1'b1}) << cif.exp) - {{(CNT_W-1){1'b0}}, 1'b1};
	assign wrap_w  = (cnt_r >= limit_w);

	// Counter and tick; a shrinking exponent wraps at once, never stalls
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_r    <= '0;
			cif.tick <= 1'b0;
		end else if (cif.clear) begin
			cnt_r    <= '0;
			cif.tick <= 1'b0;
		end else begin
			cnt_r    <= wrap_w ? '0 : cnt_r + 1'b1;
			cif.tick <= wrap_w;
		end
	end

	// Ticks are spaced by the divide ratio
	chk_tick_spacing: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(cif.tick && cif.exp != 4'h0 && !cif.clear) |=> !cif.tick)
		else $error("tick too soon for divide ratio");

endmodule // smc_cal_divider

/* hdl/smc_cal_sequencer.sv */
// Calibration engine stand-in: runs a fixed number of state machine ticks.
// Assumes start is a single-clock pulse and clear a held level from the register block.
`timescale 1ns/1ps
module smc_cal_sequencer
	import smc_pkg::*;
#(
	parameter int TICKS = SMC_CAL_TICKS              // Ticks per calibration
) (
	input  wire logic clk_i,
	input  wire logic resetn_i,
	smc_cal_if.seq    cif
);

	smc_cal_state_type state_r;                      // Engine state
	logic [7:0]        cnt_r;                        // Ticks seen in this run
	logic              last_w;                       // Final tick arriving

	assign last_w = cif.tick && (cnt_r == 8'(TICKS - 1));

	// Start restarts a run in progress, so the newest settings win
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_r <= SMC_CAL_IDLE;
			cnt_r   <= 8'h00;
			cif.done <= 1'b0;
		end else if (cif.clear) begin
			state_r <= SMC_CAL_IDLE;
			cnt_r   <= 8'h00;
			cif.done <= 1'b0;
		end else begin
			cif.done <= 1'b0;
			case (state_r)
				SMC_CAL_IDLE: begin
					cnt_r <= 8'h00;
					if (cif.start) begin
						state_r <= SMC_CAL_RUN;
					end
				end
				SMC_CAL_RUN: begin
					if (cif.start) begin
						cnt_r <= 8'h00;
					end else if (last_w) begin
						state_r  <= SMC_CAL_IDLE;
						cif.done <= 1'b1;
					end else if (cif.tick) begin
						cnt_r <= cnt_r + 8'h01;
					end
				end
				default: begin
					state_r <= SMC_CAL_IDLE;
				end
			endcase
		end
	end

	assign cif.busy = (state_r == SMC_CAL_RUN);

endmodule // smc_cal_sequencer

/* hdl/smc_main_control.sv */
// Main control register block of a wideband synthesizer, on an APB port.
// Assumes a single APB master and synchronous pin inputs on clk_i.
//
// How it works
// - Phase enable puts divider into feedback.
// - Rising phase enable sends one alignment pulse.
// - Mute bit silences outputs during calibration.
// - Speed adjust slows calibration clock; resets zero.
// - Write with trigger bit launches calibration.
// - Pin select: readback at 0, lock at 1.
// - Software reset holds registers and engines reset.
// - Sleep bit powers device down; resets zero.
// - Calibration clock is reference over two-power divider.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module smc_main_control
	import smc_pkg::*;
#(
	parameter int ADDR_W    = 10,                    // APB address width
	parameter int CAL_TICKS = SMC_CAL_TICKS          // Ticks per calibration
) (
	input  wire logic              clk_i,
	input  wire logic              resetn_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]       pwdata_i,
	input  wire logic [3:0]        pstrb_i,
	output logic [31:0]            prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	input  wire logic              lock_detect_i,
	input  wire logic              readback_data_i,
	output logic                   multiplexed_output_pin_o,
	output logic                   feedback_phase_mode_o,
	output logic                   phase_align_pulse_o,
	output logic                   rf_outputs_mute_o,
	output logic                   device_sleep_o,
	output logic                   soft_reset_o,
	output logic                   cal_busy_o
);

	// ------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------
	logic       phase_r;                             // Deterministic phase enable
	logic       mute_r;                              // Mute during calibration
	logic [1:0] adj_r;                               // Calibration speed adjust
	logic       vco_frequency_calibration_r;                              // Calibration trigger, stored
	logic       muxsel_r;                            // Output pin function select
	logic       reset_r;                             // Software reset
	logic       sleep_r;                             // Device sleep
	logic [2:0] caldiv_r;                            // Calibration clock divider
	logic       start_r;                             // Calibration launch pulse

	smc_cal_if cif ();                               // Link to calibration engine

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	logic        setup_w;                            // Setup phase of a transfer
	logic        access_w;                           // Completing access phase
	logic        wr_w;                               // Write takes effect now
	logic        sel_main_w;                         // Main control addressed
	logic        sel_div_w;                          // Divider addressed
	logic        sel_stat_w;                         // Status addressed
	logic        hit_w;                              // Any mapped register
	logic [15:0] main_cur_w;                         // Main control as read
	logic [15:0] main_new_w;                         // Main control after lane merge
	logic [15:0] div_cur_w;                          // Divider as read
	logic [15:0] div_new_w;                          // Divider after lane merge
	logic [15:0] stat_w;                             // Status as read
	logic [31:0] rd_mux_w;                           // Read data selection
	logic        wr_main_w;                          // Write to main control
	logic        wr_div_w;                           // Write to divider
	logic        new_reset_w;                        // Software reset written
	logic        new_sleep_w;                        // Sleep written
	logic        launch_w;                           // Calibration to be launched
	logic        align_w;                            // Alignment pulse to be sent
	logic        pin_nxt;                            // Next multiplexed pin level
	logic        mute_nxt;                           // Next output mute level

	assign setup_w    = psel_i & ~penable_i;
	assign access_w   = psel_i & penable_i & pready_o;
	assign wr_w       = access_w & pwrite_i;
	assign sel_main_w = (paddr_i == ADDR_W'(SMC_MAIN_ADDR));
	assign sel_div_w  = (paddr_i == ADDR_W'(SMC_CALDIV_ADDR));
	assign sel_stat_w = (paddr_i == ADDR_W'(SMC_STATUS_ADDR));
	assign hit_w      = sel_main_w | sel_div_w | sel_stat_w;

	// Reserved positions read as zero
	assign main_cur_w = {1'b0, phase_r, 4'h0, mute_r, adj_r, 3'h0, vco_frequency_calibration_r, muxsel_r, reset_r, sleep_r};
	assign div_cur_w  = {13'h0000, caldiv_r};
	assign stat_w     = {14'h0000, lock_detect_i, cif.busy};
	assign rd_mux_w   = sel_main_w ? {16'h0000, main_cur_w} :
	                    sel_div_w  ? {16'h0000, div_cur_w}  :
	                    sel_stat_w ? {16'h0000, stat_w}     : 32'h00000000;

	// Byte lanes: only the two low lanes hold bits
	assign main_new_w = {pstrb_i[1] ? pwdata_i[15:8] : main_cur_w[15:8],
	                     pstrb_i[0] ? pwdata_i[7:0]  : main_cur_w[7:0]};
	assign div_new_w  = {pstrb_i[1] ? pwdata_i[15:8] : div_cur_w[15:8],
	                     pstrb_i[0] ? pwdata_i[7:0]  : div_cur_w[7:0]};

	assign wr_main_w   = wr_w & sel_main_w;
	assign wr_div_w    = wr_w & sel_div_w;
	assign new_reset_w = main_new_w[SMC_RESET_BIT];
	assign new_sleep_w = main_new_w[SMC_SLEEP_BIT];

	// Every write carrying the trigger launches, unless the same write resets or sleeps
	assign launch_w = wr_main_w & main_new_w[SMC_VCO_FREQUENCY_CALIBRATION_BIT] & ~new_reset_w & ~new_sleep_w;
	// Only a 0 to 1 change of the stored phase bit aligns
	assign align_w  = wr_main_w & main_new_w[SMC_PHASE_BIT] & ~phase_r & ~new_reset_w;

	// ------------------------------------------------------------
	// APB answer
	// ------------------------------------------------------------
	// Ready is raised for the access phase that follows each setup
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h00000000;
		end else begin
			pready_o  <= setup_w;
			pslverr_o <= setup_w & ~hit_w;
			prdata_o  <= (setup_w & ~pwrite_i) ? rd_mux_w : 32'h00000000;
		end
	end

	// ------------------------------------------------------------
	// Software reset bit
	// ------------------------------------------------------------
	// Not self-clearing: stays until software writes zero
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reset_r <= SMC_RESET_RST;
		end else if (wr_main_w) begin
			reset_r <= new_reset_w;
		end
	end

	// ------------------------------------------------------------
	// Main control fields
	// ------------------------------------------------------------
	// A write that sets reset loads reset values; while held, nothing else changes
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			phase_r  <= SMC_PHASE_RST;
			mute_r   <= SMC_MUTE_RST;
			adj_r    <= SMC_ADJ_RST;
			vco_frequency_calibration_r   <= SMC_VCO_FREQUENCY_CALIBRATION_RST;
			muxsel_r <= SMC_MUXSEL_RST;
			sleep_r  <= SMC_SLEEP_RST;
		end else if (wr_main_w && new_reset_w) begin
			phase_r  <= SMC_PHASE_RST;
			mute_r   <= SMC_MUTE_RST;
			adj_r    <= SMC_ADJ_RST;
			vco_frequency_calibration_r   <= SMC_VCO_FREQUENCY_CALIBRATION_RST;
			muxsel_r <= SMC_MUXSEL_RST;
			sleep_r  <= SMC_SLEEP_RST;
		end else if (wr_main_w) begin
			phase_r  <= main_new_w[SMC_PHASE_BIT];
			mute_r   <= main_new_w[SMC_MUTE_BIT];
			adj_r    <= main_new_w[SMC_ADJ_HI:SMC_ADJ_LO];
			vco_frequency_calibration_r   <= main_new_w[SMC_VCO_FREQUENCY_CALIBRATION_BIT];
			muxsel_r <= main_new_w[SMC_MUXSEL_BIT];
			sleep_r  <= new_sleep_w;
		end
	end

	// ------------------------------------------------------------
	// Calibration clock divider field
	// ------------------------------------------------------------
	// Software must keep the resulting clock at or below 50 MHz
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			caldiv_r <= SMC_CALDIV_RST;
		end else if (reset_r || (wr_main_w && new_reset_w)) begin
			caldiv_r <= SMC_CALDIV_RST;
		end else if (wr_div_w) begin
			caldiv_r <= div_new_w[2:0];
		end
	end

	// ------------------------------------------------------------
	// Calibration engine link
	// ------------------------------------------------------------
	// Adjust adds to the exponent, so it can only slow the clock
	assign cif.exp   = {1'b0, caldiv_r} + {2'b00, adj_r};
	assign cif.start = start_r;
	assign cif.clear = reset_r | sleep_r;

	// Launch pulse, one cycle after the write
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			start_r <= 1'b0;
		end else begin
			start_r <= launch_w;
		end
	end

	smc_cal_divider #(
		.CNT_W (11)
	) u_divider (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.cif      (cif)
	);

	smc_cal_sequencer #(
		.TICKS (CAL_TICKS)
	) u_sequencer (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.cif      (cif)
	);

	// ------------------------------------------------------------
	// Device-facing outputs
	// ------------------------------------------------------------
	assign pin_nxt  = muxsel_r ? lock_detect_i : readback_data_i;
	assign mute_nxt = mute_r & (cif.busy | start_r);

	// All outputs registered for clean pin timing
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			multiplexed_output_pin_o <= 1'b0;
			feedback_phase_mode_o    <= 1'b0;
			phase_align_pulse_o      <= 1'b0;
			rf_outputs_mute_o        <= 1'b0;
			device_sleep_o           <= 1'b0;
			soft_reset_o             <= 1'b0;
			cal_busy_o               <= 1'b0;
		end else begin
			multiplexed_output_pin_o <= pin_nxt;
			feedback_phase_mode_o    <= phase_r;
			phase_align_pulse_o      <= align_w;
			rf_outputs_mute_o        <= mute_nxt;
			device_sleep_o           <= sleep_r;
			soft_reset_o             <= reset_r;
			cal_busy_o               <= cif.busy;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// Pulse shows first, the registered mode one cycle later
	chk_phase_mode_follow: assert property (@(posedge clk_i) disable iff (!resetn_i)
		$rose(phase_r) |-> phase_align_pulse_o ##1 feedback_phase_mode_o)
		else $error("phase mode or align pulse missing");

	chk_align_single: assert property (@(posedge clk_i) disable iff (!resetn_i)
		phase_align_pulse_o |=> feedback_phase_mode_o && !phase_align_pulse_o)
		else $error("align pulse not single");

	chk_mute_during_cal: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(mute_r && cif.busy) |=> rf_outputs_mute_o)
		else $error("outputs not muted during calibration");

	// Adjust may only lengthen the tick period, and is zero while held in reset
	chk_adj_slows_clock: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(cif.exp >= {1'b0, caldiv_r}) && (!reset_r || adj_r == SMC_ADJ_RST))
		else $error("speed adjust wrong");

	chk_vco_frequency_calibration_launch: assert property (@(posedge clk_i) disable iff (!resetn_i)
		launch_w |=> start_r ##1 cif.busy)
		else $error("calibration not launched");

	chk_pin_select: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(muxsel_r && $stable(muxsel_r) && lock_detect_i) |=> multiplexed_output_pin_o)
		else $error("lock detect not on pin");

	chk_pin_readback: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!muxsel_r |=> multiplexed_output_pin_o == $past(readback_data_i))
		else $error("readback not on pin");

	chk_reset_holds: assert property (@(posedge clk_i) disable iff (!resetn_i)
		reset_r [*2] |-> !cif.busy && caldiv_r == SMC_CALDIV_RST && !phase_r && !sleep_r)
		else $error("software reset not held");

	// Entering reset loads the trigger, pin select, divider and adjust reset values at once
	chk_reset_loads: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(wr_main_w && new_reset_w) |=> reset_r && vco_frequency_calibration_r == SMC_VCO_FREQUENCY_CALIBRATION_RST && muxsel_r == SMC_MUXSEL_RST &&
		caldiv_r == SMC_CALDIV_RST && adj_r == SMC_ADJ_RST)
		else $error("reset values not loaded");

	chk_reset_sticky: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(reset_r && !wr_main_w) |=> reset_r)
		else $error("software reset cleared itself");

	chk_sleep_out: assert property (@(posedge clk_i) disable iff (!resetn_i)
		sleep_r |-> !start_r ##1 device_sleep_o)
		else $error("sleep not applied");

	chk_sleep_clears_cal: assert property (@(posedge clk_i) disable iff (!resetn_i)
		sleep_r |=> !cif.busy)
		else $error("calibration runs while asleep");

	chk_apb_ready: assert property (@(posedge clk_i) disable iff (!resetn_i)
		setup_w |=> pready_o ##1 !pready_o || setup_w)
		else $error("apb ready timing wrong");

	// Read bus stays at zero outside the answering cycle
	chk_rdata_idle: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!pready_o |-> prdata_o == 32'h00000000)
		else $error("read data outside access");

	chk_slverr_unmapped: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(setup_w && !hit_w) |=> pready_o && pslverr_o)
		else $error("unmapped access not flagged");

	cov_cal_done: cover property (@(posedge clk_i) disable iff (!resetn_i) cif.done);
	cov_muted_cal: cover property (@(posedge clk_i) disable iff (!resetn_i) rf_outputs_mute_o && cal_busy_o);
	cov_align: cover property (@(posedge clk_i) disable iff (!resetn_i) phase_align_pulse_o);
	cov_soft_reset: cover property (@(posedge clk_i) disable iff (!resetn_i) $fell(reset_r));
	cov_slverr: cover property (@(posedge clk_i) disable iff (!resetn_i) pslverr_o && pready_o);

endmodule // smc_main_control

/* bench/tb_top.sv */
// Self-checking bench for the synthesizer main control block.
// Assumes smc_pkg and the design files are compiled first; APB driven here.
`timescale 1ns/1ps
module tb_top
	import smc_pkg::*;
;
	// ------------------------------------------------------------
	// Stimulus and observation signals
	// ------------------------------------------------------------
	logic        clk_i     = 1'b0;    // 250 MHz system clock
	logic        resetn_i  = 1'b0;    // Held low at start
	logic        psel_i    = 1'b0;    // APB select
	logic        penable_i = 1'b0;    // APB access phase
	logic        pwrite_i  = 1'b0;    // APB direction
	logic [9:0]  paddr_i   = 10'h000; // APB byte address
	logic [31:0] pwdata_i  = 32'h0;   // APB write data
	logic [3:0]  pstrb_i   = 4'h3;    // Both used lanes enabled
	logic        lock_i    = 1'b1;    // Lock indication in
	logic        rb_i      = 1'b0;    // Readback bit in
	logic [31:0] prdata_o, rd;        // Read data and captured copy
	logic        pready_o, pslverr_o, er, pin_o, fb_o, pulse_o, mute_o, sleep_o, srst_o, busy_o;
	int          err_count, num_checks, pulse_cnt, len0, len1, m;

	// Clock: half period of 2 ns
	always #2 clk_i = ~clk_i;

	// Count alignment pulses; each lasts one cycle
	always @(posedge clk_i) if (pulse_o === 1'b1) pulse_cnt++;

	// Short calibration so the run stays brief
	smc_main_control #(.ADDR_W(10), .CAL_TICKS(4)) uut (
		.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.lock_detect_i(lock_i), .readback_data_i(rb_i), .multiplexed_output_pin_o(pin_o),
		.feedback_phase_mode_o(fb_o), .phase_align_pulse_o(pulse_o), .rf_outputs_mute_o(mute_o),
		.device_sleep_o(sleep_o), .soft_reset_o(srst_o), .cal_busy_o(busy_o));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	// Compare and count; four-state equality so unknowns fail
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Verdict and end of run
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// One APB transfer; entered just after a rising edge
	task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i  <= wr;
		paddr_i   <= a;
		pwdata_i  <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 16);
		rd = prdata_o;
		er = pslverr_o;
		if (pready_o !== 1'b1) begin // Bounded wait ran out
			err_count++;
			finish_test();
		end
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
		// Idle edge so the next setup never lands in the same step
		@(posedge clk_i);
	endtask

	task automatic rdchk(input string name, input logic [9:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(name, rd, exp);
	endtask

	// Registered outputs trail by a cycle; three edges is ample
	task automatic settle;
		repeat (3) @(posedge clk_i);
	endtask

	// Wait for busy, then measure its length and the muted cycles
	task automatic cal_len(output int len);
		int n;
		n = 0;
		len = 0;
		m = 0;
		while (busy_o !== 1'b1 && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		while (busy_o === 1'b1 && len < 400) begin
			if (mute_o === 1'b1) m++;
			@(posedge clk_i);
			len++;
		end
		// Either bound running out means a hang
		if (len == 0 || len >= 400) begin
			err_count++;
			finish_test();
		end
		@(posedge clk_i);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		rdchk("main reset", SMC_MAIN_ADDR, 32'h0000000C);
		rdchk("div reset", SMC_CALDIV_ADDR, 32'h00000004);
		rdchk("status idle", SMC_STATUS_ADDR, 32'h00000002);
		apb(1'b0, 10'h00C, 32'h0);
		check("unmapped err", er, 32'h1);
		check("unmapped data", rd, 32'h0);
		// Host pulses software reset before any configuration
		apb(1'b1, SMC_MAIN_ADDR, 32'h0002);
		apb(1'b1, SMC_MAIN_ADDR, 32'h0004);
		$display("test reset_map done");
		// Pin follows lock at select 1, readback at select 0
		check("pin lock hi", pin_o, 32'h1);
		lock_i <= 1'b0;
		settle();
		check("pin lock lo", pin_o, 32'h0);
		apb(1'b1, SMC_MAIN_ADDR, 32'h0000);
		rb_i <= 1'b1;
		settle();
		check("pin readback", pin_o, 32'h1);
		$display("test pin_select done");
		// Software reset holds fields and does not clear itself
		apb(1'b1, SMC_MAIN_ADDR, 32'h0002);
		apb(1'b1, SMC_MAIN_ADDR, 32'h4203);
		apb(1'b1, SMC_CALDIV_ADDR, 32'h0);
		repeat (20) @(posedge clk_i);
		check("soft reset held", srst_o, 32'h1);
		check("sleep blocked", sleep_o, 32'h0);
		rdchk("main in reset", SMC_MAIN_ADDR, 32'h0000000E);
		rdchk("div in reset", SMC_CALDIV_ADDR, 32'h00000004);
		apb(1'b1, SMC_MAIN_ADDR, 32'h0000);
		settle();
		check("soft reset off", srst_o, 32'h0);
		rdchk("main released", SMC_MAIN_ADDR, 32'h0);
		$display("test soft_reset done");
		// Phase mode, one pulse per rising edge of the bit only
		pulse_cnt = 0;
		apb(1'b1, SMC_MAIN_ADDR, 32'h4000);
		apb(1'b1, SMC_MAIN_ADDR, 32'h4000);
		settle();
		check("phase mode on", fb_o, 32'h1);
		check("align pulses", pulse_cnt, 32'h1);
		apb(1'b1, SMC_MAIN_ADDR, 32'h0000);
		settle();
		check("phase mode off", fb_o, 32'h0);
		$display("test phase done");
		// Calibration with mute, speed adjust 0 then 1
		apb(1'b1, SMC_CALDIV_ADDR, 32'h0);
		apb(1'b1, SMC_MAIN_ADDR, 32'h0208);
		cal_len(len0);
		check("cal ran", len0 >= 4, 32'h1);
		check("muted in cal", m + 1 >= len0, 32'h1);
		check("mute after cal", mute_o, 32'h0);
		apb(1'b1, SMC_MAIN_ADDR, 32'h0288);
		cal_len(len1);
		check("slower cal", len1 + 2 >= 2 * len0, 32'h1);
		apb(1'b1, SMC_MAIN_ADDR, 32'h0008);
		cal_len(len0);
		check("cal retrigger", len0 >= 4, 32'h1);
		check("no mute", m, 32'h0);
		$display("test calibration done");
		// Sleep blocks calibration launch
		apb(1'b1, SMC_MAIN_ADDR, 32'h0009);
		settle();
		check("sleep on", sleep_o, 32'h1);
		check("no cal asleep", busy_o, 32'h0);
		apb(1'b1, SMC_MAIN_ADDR, 32'h0000);
		settle();
		check("sleep off", sleep_o, 32'h0);
		// Divider field keeps only three bits
		apb(1'b1, SMC_CALDIV_ADDR, 32'h000000FD);
		rdchk("div width", SMC_CALDIV_ADDR, 32'h00000005);
		$display("test sleep_div done");
		finish_test();
	end
endmodule // tb_top
